// file: core/irl_request_latch.sv
// first interrupt request register with core vectoring and watchdog flag clear
`timescale 1ns/1ps

// Overview of operation
// - a presented peripheral request sets its bit in the request register
// - with global enable on, a latched request is vectored to the core
// - with global enable off, pending bits stay readable for polling
// - eight-bit request register at FC0H, bits 6,5,4,3,0 used, reset 0
// - timer 1 bit reads 1 while its request awaits service
// - timer 0 bit reads 1 while its request awaits service
// - watchdog and oscillator traps bypass enable and request registers
// - reading reset status clears the watchdog flag at bit 5
module irl_request_latch
(
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // register port
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    // peripheral request pulses
    input  wire logic        i_timer1_request,
    input  wire logic        i_timer0_request,
    input  wire logic        i_uart0_receive_request,
    input  wire logic        i_uart0_transmit_request,
    input  wire logic        i_converter_request,
    // trap and watchdog sources
    input  wire logic        i_wdt_event,
    input  wire logic        i_osc_fail,
    input  wire logic        i_wdt_osc_fail,
    // core side
    output logic             o_core_irq,
    output logic [2:0]       o_core_vector,
    input  wire logic        i_core_ack,
    output logic             o_trap,
    // block status interrupt
    output logic             o_irq
);
    logic [7:0] interrupt_request_lo;
    logic [7:0] reset_status_reg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       global_enable;
    logic [2:0] last_vector;
    logic [7:0] raise;
    logic [7:0] ack_clear;
    logic [7:0] next_request;
    logic       pend_any;
    logic [2:0] pend_index;
    logic       wr_req;
    logic       rd_rstat;
    logic [7:0] next_rdata;

    // decode shared between write and read paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    assign wr_req   = i_wr && hit(i_addr, irl_pkg::IRL_ADDR_REQ_LO);
    assign rd_rstat = i_rd && hit(i_addr, irl_pkg::IRL_ADDR_RESET_STAT);

    // request pulses mapped onto their bit positions
    always_comb
    begin
        raise = 8'h00;
        raise[irl_pkg::IRL_BIT_TIMER1]    = i_timer1_request;
        raise[irl_pkg::IRL_BIT_TIMER0]    = i_timer0_request;
        raise[irl_pkg::IRL_BIT_UART0_RX]  = i_uart0_receive_request;
        raise[irl_pkg::IRL_BIT_UART0_TX]  = i_uart0_transmit_request;
        raise[irl_pkg::IRL_BIT_CONVERTER] = i_converter_request;
        raise = raise & irl_pkg::IRL_REQ_SOURCES;
    end

    // priority pick of what is pending for the core
    irl_priority #(.WIDTH(8)) u_pick
    (
        .i_pending (interrupt_request_lo & irl_pkg::IRL_REQ_SOURCES),
        .o_any     (pend_any),
        .o_index   (pend_index)
    );

    // acknowledge clears only the bit that was presented to the core
    always_comb
    begin
        ack_clear = 8'h00;
        if (i_core_ack && global_enable)
        begin
            ack_clear[last_vector] = 1'b1;
        end
    end

    // software write replaces the value, ack clears, new requests always win
    always_comb
    begin
        next_request = interrupt_request_lo & ~ack_clear;
        if (wr_req)
        begin
            next_request = i_wdata;
        end
        next_request = next_request | raise;
    end

    // request register storage
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            interrupt_request_lo <= irl_pkg::IRL_REQ_RESET;
        else
            interrupt_request_lo <= next_request;
    end

    // global enable lives in a control register of this block
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            global_enable <= irl_pkg::IRL_GIE_RESET;
        else if (i_wr && hit(i_addr, irl_pkg::IRL_ADDR_CONTROL))
            global_enable <= i_wdata[irl_pkg::IRL_BIT_GIE];
    end

    // vector to core only while enabled; polled mode leaves bits alone
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_core_irq    <= 1'b0;
            o_core_vector <= 3'h0;
            last_vector   <= 3'h0;
        end
        else
        begin
            o_core_irq    <= global_enable && pend_any && !i_core_ack;
            o_core_vector <= pend_index;
            last_vector   <= pend_index;
        end
    end

    // watchdog flag: set by the watchdog, cleared by a read of reset status
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            reset_status_reg <= irl_pkg::IRL_RSTAT_RESET;
        else if (i_wdt_event)
            reset_status_reg[irl_pkg::IRL_BIT_WDT_FLAG] <= 1'b1;
        else if (rd_rstat)
            reset_status_reg[irl_pkg::IRL_BIT_WDT_FLAG] <= 1'b0;
    end

    // traps go straight to the core, no enable or request bits involved
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_trap <= 1'b0;
        else
            o_trap <= reset_status_reg[irl_pkg::IRL_BIT_WDT_FLAG]
                      || i_osc_fail || i_wdt_osc_fail;
    end

    // sticky status, write one to clear; set beats clear
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            irq_status <= irl_pkg::IRL_STATUS_RESET;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == irl_pkg::IRL_EV_VECTOR && i_core_ack && global_enable)
                    || (i == irl_pkg::IRL_EV_WDT && i_wdt_event))
                    irq_status[i] <= 1'b1;
                else if (i_wr && hit(i_addr, irl_pkg::IRL_ADDR_IRQ_STATUS) && i_wdata[i])
                    irq_status[i] <= 1'b0;
            end
        end
    end

    // mask register
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            irq_mask <= irl_pkg::IRL_MASK_RESET;
        else if (i_wr && hit(i_addr, irl_pkg::IRL_ADDR_IRQ_MASK))
            irq_mask <= i_wdata[1:0];
    end

    assign o_irq = |(irq_status & irq_mask);

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit(i_addr, irl_pkg::IRL_ADDR_REQ_LO))
            next_rdata = interrupt_request_lo;
        else if (hit(i_addr, irl_pkg::IRL_ADDR_RESET_STAT))
            next_rdata = reset_status_reg;
        else if (hit(i_addr, irl_pkg::IRL_ADDR_IRQ_STATUS))
            next_rdata = {6'h00, irq_status};
        else if (hit(i_addr, irl_pkg::IRL_ADDR_IRQ_MASK))
            next_rdata = {6'h00, irq_mask};
        else if (hit(i_addr, irl_pkg::IRL_ADDR_CONTROL))
            next_rdata = {7'h00, global_enable};
        else if (hit(i_addr, irl_pkg::IRL_ADDR_VECTOR))
            next_rdata = {4'h0, pend_any, pend_index};
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= 8'h00;
    end
endmodule

// file: core/irl_pkg.sv
// package of register map, field positions and reset values for the request latch
package irl_pkg;
    localparam logic [11:0] IRL_ADDR_REQ_LO      = 12'hFC0;
    localparam logic [11:0] IRL_ADDR_RESET_STAT  = 12'hFC4;
    localparam logic [11:0] IRL_ADDR_IRQ_STATUS  = 12'hFC8;
    localparam logic [11:0] IRL_ADDR_IRQ_MASK    = 12'hFC9;
    localparam logic [11:0] IRL_ADDR_CONTROL     = 12'hFCA;
    localparam logic [11:0] IRL_ADDR_VECTOR      = 12'hFCB;

    localparam int          IRL_BIT_TIMER1       = 6;
    localparam int          IRL_BIT_TIMER0       = 5;
    localparam int          IRL_BIT_UART0_RX     = 4;
    localparam int          IRL_BIT_UART0_TX     = 3;
    localparam int          IRL_BIT_CONVERTER    = 0;
    localparam int          IRL_BIT_WDT_FLAG     = 5;
    localparam int          IRL_BIT_GIE          = 0;

    // implemented request bits; 7, 2 and 1 are reserved but still storage
    localparam logic [7:0]  IRL_REQ_SOURCES      = 8'h79;
    localparam logic [7:0]  IRL_REQ_RESET        = 8'h00;
    localparam logic [7:0]  IRL_RSTAT_RESET      = 8'h00;
    localparam logic [1:0]  IRL_STATUS_RESET     = 2'h0;
    localparam logic [1:0]  IRL_MASK_RESET       = 2'h0;
    localparam logic        IRL_GIE_RESET        = 1'b0;
    localparam int          IRL_EV_VECTOR        = 0;
    localparam int          IRL_EV_WDT           = 1;
endpackage

// file: core/irl_priority.sv
// fixed priority picker: highest pending request bit wins
`timescale 1ns/1ps
module irl_priority
#(
    parameter int WIDTH = 8
)
(
    input  wire logic [WIDTH-1:0] i_pending,
    output logic                  o_any,
    output logic [2:0]            o_index
);
    // scan upward so the highest set bit is kept last
    always_comb
    begin
        o_any   = 1'b0;
        o_index = 3'h0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (i_pending[i])
            begin
                o_any   = 1'b1;
                o_index = 3'(i);
            end
        end
    end
endmodule

// file: verification/irl_checker.sv
// port relation checker for the request latch
`timescale 1ns/1ps
module irl_checker
(
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic [11:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  o_rdata,
    input  wire logic        i_timer1_request,
    input  wire logic        i_timer0_request,
    input  wire logic        i_converter_request,
    input  wire logic        i_wdt_event,
    input  wire logic        i_osc_fail,
    input  wire logic        o_trap,
    input  wire logic        o_core_irq,
    input  wire logic        i_core_ack
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic rq;
    logic rs;
    // read strobes aimed at the request and reset status registers
    assign rq = i_rd && i_addr == irl_pkg::IRL_ADDR_REQ_LO;
    assign rs = i_rd && i_addr == irl_pkg::IRL_ADDR_RESET_STAT && !i_wdt_event;
    timer1_bit_a: assert property (i_timer1_request ##1 rq |=> o_rdata[6])
        else $error("timer 1 request not latched");
    timer0_bit_a: assert property (i_timer0_request ##1 rq |=> o_rdata[5])
        else $error("timer 0 request not latched");
    converter_bit_a: assert property (i_converter_request ##1 rq |=> o_rdata[0])
        else $error("converter request not latched");
    wdt_flag_set_a: assert property (i_wdt_event ##1 rs |=> o_rdata[5])
        else $error("watchdog flag not set");
    wdt_read_clear_a: assert property (rs ##1 rs |=> !o_rdata[5])
        else $error("watchdog flag not cleared by read");
    trap_follow_a: assert property ($rose(i_osc_fail) |=> o_trap)
        else $error("oscillator trap not raised");
    ack_drop_a: assert property (i_core_ack |-> ##1 !o_core_irq)
        else $error("core request stands after ack");
    idle_rdata_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data without read");
endmodule

// file: verification/irl_core_model.sv
// core model: acknowledges each vectored request after a chosen pause
`timescale 1ns/1ps
module irl_core_model
(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_irq,
    input  wire logic [1:0] i_pace,
    output logic            o_ack
);
    logic [1:0] wait_cnt;
    // one-cycle ack; a slow pace lets the request stand a while first
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || o_ack || !i_irq)
        begin
            o_ack    <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (wait_cnt == i_pace)
            o_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule

// file: verification/irl_request_latch_bench.sv
// bench for the request latch: register model, core partner, traps
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module irl_request_latch_bench;
    localparam logic [11:0] a_req = irl_pkg::IRL_ADDR_REQ_LO;
    localparam logic [11:0] a_rst = irl_pkg::IRL_ADDR_RESET_STAT;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack, cirq, trap, irq, was_rd;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00, req_m = 8'h00, rdata, d;
    logic [5:0]  ev = 6'h00;
    logic [1:0]  osc = 2'h0, pace = 2'h0;
    logic [2:0]  vec;
    logic [7:0]  exp_q[$];
    int          num_errors = 0, cmp_count = 0, n;
    irl_request_latch dut (.i_mclk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer1_request(ev[4]),
        .i_timer0_request(ev[3]), .i_uart0_receive_request(ev[2]),
        .i_uart0_transmit_request(ev[1]), .i_converter_request(ev[0]), .i_wdt_event(ev[5]),
        .i_osc_fail(osc[0]), .i_wdt_osc_fail(osc[1]), .o_core_irq(cirq),
        .o_core_vector(vec), .i_core_ack(ack), .o_trap(trap), .o_irq(irq));
    irl_core_model core (.i_mclk(clk), .i_sys_rst(rst), .i_irq(cirq), .i_pace(pace),
        .o_ack(ack));
    initial
    begin
        forever #10 clk = ~clk;
    end
    // highest pending bit, as the core should see it vectored
    function automatic logic [2:0] hi(input logic [7:0] v);
        hi = 3'h0;
        for (int i = 0; i < 8; i++) if (v[i]) hi = i[2:0];
    endfunction
    // one bus cycle: k=1 write, k=2 read expecting v, plus request pulses e
    task automatic cyc(input logic [1:0] k, input logic [11:0] a, input logic [7:0] v,
                       input logic [5:0] e);
        @(posedge clk);
        wr    <= (k == 2'h1);
        rd    <= (k == 2'h2);
        addr  <= a;
        wdata <= v;
        ev    <= e;
        if (k == 2'h2) exp_q.push_back(v);
        if (k == 2'h1 && a == a_req) req_m = v;
        req_m = req_m | {1'b0, e[4:1], 2'h0, e[0]};
        #1;
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // every read result and every acknowledged vector against the model
    always @(posedge clk)
    begin
        was_rd = rd;
        if (ack === 1'b1)
        begin
            `CHK(vec, hi(req_m))
            req_m[hi(req_m)] = 1'b0;
        end
        #1;
        if (was_rd) `CHK(rdata, exp_q.pop_front())
    end
    initial
    begin
        void'($urandom(63));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(2'h2, a_req, 8'h00, 6'h00);
        cyc(2'h2, 12'hFFF, 8'h00, 6'h00);
        // polled mode: each source alone, read straight after its pulse
        for (int i = 0; i < 5; i++)
        begin
            cyc(2'h0, 12'h000, 8'h00, 6'h01 << i);
            cyc(2'h2, a_req, req_m, 6'h00);
        end
        cyc(2'h2, irl_pkg::IRL_ADDR_VECTOR, {5'h01, hi(req_m)}, 6'h00);
        `CHK(cirq, 1'b0)
        repeat (4)
        begin
            d = 8'($urandom) & 8'h7F;
            cyc(2'h1, a_req, d, 6'h00);
            cyc(2'h2, a_req, d, 6'($urandom) & 6'h1F);
        end
        cyc(2'h1, a_req, 8'h00, 6'h00);
        // vectored mode with a prompt and a slow core
        for (int p = 0; p < 4; p += 3)
        begin
            @(posedge clk);
            pace <= p[1:0];
            cyc(2'h1, irl_pkg::IRL_ADDR_CONTROL, 8'h01, 6'h11);
            for (n = 0; n < 60 && req_m != 8'h00; n++) cyc(2'h0, 12'h000, 8'h00, 6'h00);
            if (req_m != 8'h00)
            begin
                num_errors++;
                $display("CHECK FAILED %0t vectoring timed out", $time);
                finish_test();
            end
            cyc(2'h2, irl_pkg::IRL_ADDR_CONTROL, 8'h01, 6'h00);
            cyc(2'h1, irl_pkg::IRL_ADDR_CONTROL, 8'h00, 6'h00);
            cyc(2'h2, a_req, 8'h00, 6'h00);
        end
        // watchdog flag, its status bit and the masked block interrupt
        cyc(2'h2, irl_pkg::IRL_ADDR_IRQ_STATUS, 8'h01, 6'h00);
        cyc(2'h1, irl_pkg::IRL_ADDR_IRQ_STATUS, 8'h03, 6'h00);
        cyc(2'h0, 12'h000, 8'h00, 6'h20);
        cyc(2'h2, a_rst, 8'h20, 6'h00);
        cyc(2'h2, a_rst, 8'h00, 6'h00);
        `CHK(trap, 1'b1)
        `CHK(irq, 1'b0)
        cyc(2'h1, irl_pkg::IRL_ADDR_IRQ_MASK, 8'h02, 6'h00);
        cyc(2'h2, irl_pkg::IRL_ADDR_IRQ_MASK, 8'h02, 6'h00);
        `CHK(irq, 1'b1)
        cyc(2'h2, irl_pkg::IRL_ADDR_IRQ_STATUS, 8'h02, 6'h00);
        cyc(2'h1, irl_pkg::IRL_ADDR_IRQ_STATUS, 8'h02, 6'h00);
        cyc(2'h0, 12'h000, 8'h00, 6'h00);
        `CHK({irq, trap}, 2'h0)
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            osc <= 2'(1 << i);
            cyc(2'h0, 12'h000, 8'h00, 6'h00);
            cyc(2'h0, 12'h000, 8'h00, 6'h00);
            `CHK(trap, 1'b1)
            @(posedge clk);
            osc <= 2'h0;
        end
        cyc(2'h0, 12'h000, 8'h00, 6'h00);
        finish_test();
    end
endmodule
bind irl_request_latch irl_checker chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer1_request(i_timer1_request),
    .i_timer0_request(i_timer0_request), .i_converter_request(i_converter_request),
    .i_wdt_event(i_wdt_event), .i_osc_fail(i_osc_fail), .o_trap(o_trap),
    .o_core_irq(o_core_irq), .i_core_ack(i_core_ack));
